// file: logic/ccr_pkg.sv
/*
  Shared types and constants for the core clock ratio strap decoder.
  Assumes one 10 MHz bus clock and a classic Wishbone slave port.
*/
package ccr_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;

  // ratio strap codes with special meaning
  localparam logic [3:0] CCR_CODE_X8     = 4'h1;
  localparam logic [3:0] CCR_CODE_BYPASS = 4'h3;
  localparam logic [3:0] CCR_CODE_OFF    = 4'hf;

  // multipliers and ratios, ratio counted in half steps
  localparam logic [3:0] CCR_VCO_X2   = 4'h2;
  localparam logic [3:0] CCR_VCO_X8   = 4'h8;
  localparam logic [3:0] CCR_RATIO_1X = 4'h2;
  localparam logic [3:0] CCR_RATIO_7X = 4'he;

  // register byte offsets
  localparam logic [3:0] CCR_OFF_STATUS = 4'h0;
  localparam logic [3:0] CCR_OFF_CTRL   = 4'h4;

  localparam logic CCR_CTRL_MASK_RST = 1'b0;

  // how a strap is wired on the board
  typedef enum logic [1:0] {
    CCR_TIE_HIGH,
    CCR_TIE_LOW,
    CCR_TIE_RST,
    CCR_TIE_INV
  } ccr_strap_t;

  typedef struct packed {
    logic [3:0] ratio_x2;
    logic [3:0] vco_mult;
    logic       bypass;
    logic       clk_off;
    logic       pll_on;
  } ccr_cfg_t;

  localparam ccr_cfg_t CCR_CFG_RST = '{CCR_RATIO_1X, CCR_VCO_X2, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic [6:0] rsvd;
    ccr_strap_t out_cls;
    ccr_strap_t in_cls;
    logic       out_valid;
    logic       in_valid;
    logic       fast;
    logic       clock_output_pin_en;
    logic       hyst;
    logic       cfg_valid;
    ccr_cfg_t   cfg;
    logic [3:0] code;
  } ccr_status_t;

  function automatic ccr_cfg_t ccr_decode(input logic [3:0] code);
    ccr_cfg_t c;
    c = '{CCR_RATIO_1X, CCR_VCO_X2, 1'b0, 1'b0, 1'b1};
    case (code)
      4'h0: c.ratio_x2 = 4'h2;
      4'h1: c.vco_mult = CCR_VCO_X8;
      4'hc: c.ratio_x2 = 4'h3;
      4'h4: c.ratio_x2 = 4'h4;
      4'h6: c.ratio_x2 = 4'h5;
      4'h8: c.ratio_x2 = 4'h6;
      4'he: c.ratio_x2 = 4'h7;
      4'ha: c.ratio_x2 = 4'h8;
      4'h7: c.ratio_x2 = 4'h9;
      4'hb: c.ratio_x2 = 4'ha;
      4'h9: c.ratio_x2 = 4'hb;
      4'hd: c.ratio_x2 = 4'hc;
      4'h5: c.ratio_x2 = 4'hd;
      4'h2: c.ratio_x2 = CCR_RATIO_7X;
      4'h3: begin
        c.bypass = 1'b1;
        c.pll_on = 1'b0;
      end
      default: begin
        c.ratio_x2 = 4'h0;
        c.clk_off  = 1'b1;
        c.pll_on   = 1'b0;
      end
    endcase
    return c;
  endfunction

endpackage

// file: logic/ccr_strap_sense.sv
/*
  Classifies one strap pin by its level during and just after hard reset.
  Assumes the strap is static apart from following the hard reset net.
*/
`timescale 1ns/1ns
module ccr_strap_sense (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          strap_i,
  input  wire logic          hard_reset_n_i,
  output ccr_pkg::ccr_strap_t cls_o,
  output logic               valid_o
);
  import ccr_pkg::*;

  typedef enum logic [1:0] {SENSE_IDLE, SENSE_HELD, SENSE_DONE} ccr_sense_st_t;

  ccr_sense_st_t st_r;
  ccr_sense_st_t st_nxt;
  logic          held_r;
  logic          held_nxt;
  ccr_strap_t    cls_r;
  ccr_strap_t    cls_nxt;
  logic          valid_r;
  logic          valid_nxt;

  always_comb begin
    st_nxt    = st_r;
    held_nxt  = held_r;
    cls_nxt   = cls_r;
    valid_nxt = valid_r;
    case (st_r)
      SENSE_HELD: begin
        if (hard_reset_n_i) begin
          // level in reset paired with level after release
          case ({held_r, strap_i})
            2'b11:   cls_nxt = CCR_TIE_HIGH;
            2'b00:   cls_nxt = CCR_TIE_LOW;
            2'b01:   cls_nxt = CCR_TIE_RST;
            default: cls_nxt = CCR_TIE_INV;
          endcase
          st_nxt    = SENSE_DONE;
          valid_nxt = 1'b1;
        end
      end
      default: ;
    endcase
    if (!hard_reset_n_i) begin
      st_nxt    = SENSE_HELD;
      held_nxt  = strap_i;
      valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r    <= SENSE_IDLE;
      held_r  <= 1'b1;
      cls_r   <= CCR_TIE_HIGH;
      valid_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      held_r  <= held_nxt;
      cls_r   <= cls_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign cls_o   = cls_r;
  assign valid_o = valid_r;

endmodule

// file: logic/ccr_top.sv
/*
  Power-on strap decoder: core clock ratio, input buffer mode, output timing.
  Assumes straps are tied to supply, ground, hard reset or its inverse,
  and that software reaches the status over classic Wishbone.
*/
`timescale 1ns/1ns

// Notes on behaviour
// - ratio strap selects core ratio 1:1 to 7:1 in halves; code 0001 gives x8
// - code 0011 bypasses the PLL, core runs on bus clock, bus ratio 1:1
// - input strap high: no hysteresis, clock output driven (default)
// - input strap low: hysteresis on, clock output high impedance
// - input strap on hard reset: hysteresis on, clock output driven
// - input strap on inverted hard reset: no hysteresis, output high impedance
// - output strap low or on hard reset: fast output timing
// - output strap high or on inverted hard reset: compatibility timing
module ccr_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hard_reset_n_i,
  input  wire logic [3:0]  ratio_strap_i,
  input  wire logic        input_mode_strap_i,
  input  wire logic        output_mode_strap_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output ccr_pkg::ccr_cfg_t cfg_o,
  output logic             cfg_valid_o,
  output logic             core_clk_en_o,
  output logic             hysteresis_en_o,
  output logic             fast_output_timing_o,
  output logic             clock_output_pin_o,
  output logic             clock_output_pin_oe_o
);
  import ccr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // strap sensing

  ccr_strap_t in_cls;
  logic       in_valid;
  ccr_strap_t out_cls;
  logic       out_valid;

  ccr_strap_sense u_in_sense (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .strap_i        (input_mode_strap_i),
    .hard_reset_n_i (hard_reset_n_i),
    .cls_o          (in_cls),
    .valid_o        (in_valid)
  );

  ccr_strap_sense u_out_sense (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .strap_i        (output_mode_strap_i),
    .hard_reset_n_i (hard_reset_n_i),
    .cls_o          (out_cls),
    .valid_o        (out_valid)
  );

  //////////////////////////////////////////////////////////////////////////////
  // ratio capture at hard reset release

  logic       hrst_q_r;
  logic       hrst_q_nxt;
  logic [3:0] code_r;
  logic [3:0] code_nxt;
  ccr_cfg_t   cfg_r;
  ccr_cfg_t   cfg_nxt;
  logic       cfg_valid_r;
  logic       cfg_valid_nxt;
  logic       release_w;

  assign release_w = hard_reset_n_i && !hrst_q_r;

  always_comb begin
    hrst_q_nxt    = hard_reset_n_i;
    code_nxt      = code_r;
    cfg_nxt       = cfg_r;
    cfg_valid_nxt = cfg_valid_r;
    if (!hard_reset_n_i) begin
      cfg_valid_nxt = 1'b0;
    end else if (release_w) begin
      code_nxt      = ratio_strap_i;
      cfg_nxt       = ccr_decode(ratio_strap_i);
      cfg_valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hrst_q_r    <= 1'b1;
      code_r      <= CCR_CODE_OFF;
      cfg_r       <= CCR_CFG_RST;
      cfg_valid_r <= 1'b0;
    end else begin
      hrst_q_r    <= hrst_q_nxt;
      code_r      <= code_nxt;
      cfg_r       <= cfg_nxt;
      cfg_valid_r <= cfg_valid_nxt;
    end
  end

  // bypass and ratio modes both clock the core every bus cycle here
  assign core_clk_en_o = cfg_valid_r && !cfg_r.clk_off;
  assign cfg_o         = cfg_r;
  assign cfg_valid_o   = cfg_valid_r;

  //////////////////////////////////////////////////////////////////////////////
  // buffer modes and clock output

  logic hyst_r;
  logic hyst_nxt;
  logic oe_r;
  logic oe_nxt;
  logic fast_r;
  logic fast_nxt;
  logic clk_out_r;
  logic clk_out_nxt;
  logic mask_r;
  logic mask_nxt;

  always_comb begin
    hyst_nxt = (in_cls == CCR_TIE_LOW) || (in_cls == CCR_TIE_RST);
    oe_nxt   = (in_cls == CCR_TIE_HIGH) || (in_cls == CCR_TIE_RST);
    fast_nxt = (out_cls == CCR_TIE_LOW) || (out_cls == CCR_TIE_RST);
    // stopped core leaves the output low
    clk_out_nxt = core_clk_en_o ? !clk_out_r : 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hyst_r    <= 1'b0;
      oe_r      <= 1'b1;
      fast_r    <= 1'b0;
      clk_out_r <= 1'b0;
    end else begin
      hyst_r    <= hyst_nxt;
      oe_r      <= oe_nxt;
      fast_r    <= fast_nxt;
      clk_out_r <= clk_out_nxt;
    end
  end

  assign hysteresis_en_o       = hyst_r;
  assign fast_output_timing_o  = fast_r;
  assign clock_output_pin_oe_o = oe_r;
  assign clock_output_pin_o    = clk_out_r && !mask_r;

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  ccr_status_t status_w;

  always_comb begin
    status_w           = '0;
    status_w.code      = code_r;
    status_w.cfg       = cfg_r;
    status_w.cfg_valid = cfg_valid_r;
    status_w.hyst      = hyst_r;
    status_w.clock_output_pin_en = oe_r;
    status_w.fast      = fast_r;
    status_w.in_valid  = in_valid;
    status_w.out_valid = out_valid;
    status_w.in_cls    = in_cls;
    status_w.out_cls   = out_cls;
  end

  always_comb begin
    ack_nxt  = wb_cyc_i && wb_stb_i && !ack_r;
    dat_nxt  = '0;
    mask_nxt = mask_r;
    if (ack_nxt) begin
      case (wb_adr_i)
        CCR_OFF_STATUS: dat_nxt = status_w;
        CCR_OFF_CTRL: begin
          dat_nxt = {31'h0000_0000, mask_r};
          if (wb_we_i && wb_sel_i[0]) begin
            mask_nxt = wb_dat_i[0];
          end
        end
        default: dat_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      dat_r  <= '0;
      mask_r <= CCR_CTRL_MASK_RST;
    end else begin
      ack_r  <= ack_nxt;
      dat_r  <= dat_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_release(logic [3:0] c);
    !hrst_q_r ##0 hard_reset_n_i ##0 (ratio_strap_i == c);
  endsequence

  sequence s_in_tie(logic lvl_rst, logic lvl_run);
    (!hard_reset_n_i && input_mode_strap_i == lvl_rst)
      ##1 (hard_reset_n_i && input_mode_strap_i == lvl_run);
  endsequence

  sequence s_out_tie(logic lvl_rst, logic lvl_run);
    (!hard_reset_n_i && output_mode_strap_i == lvl_rst)
      ##1 (hard_reset_n_i && output_mode_strap_i == lvl_run);
  endsequence

  property p_ratio_x8;
    @(posedge clk_i) disable iff (rst_i)
      s_release(CCR_CODE_X8) |=> cfg_o.vco_mult == CCR_VCO_X8 && cfg_o.ratio_x2 == CCR_RATIO_1X;
  endproperty
  a_ratio_x8: assert property (p_ratio_x8) else $error("code 1 not x8 at 1:1");

  property p_ratio_7;
    @(posedge clk_i) disable iff (rst_i)
      s_release(4'h2) |=> cfg_o.vco_mult == CCR_VCO_X2 && cfg_o.ratio_x2 == CCR_RATIO_7X
                          && cfg_valid_o && core_clk_en_o && cfg_o.pll_on;
  endproperty
  a_ratio_7: assert property (p_ratio_7) else $error("code 2 not 7:1 x2");

  property p_bypass;
    @(posedge clk_i) disable iff (rst_i)
      s_release(CCR_CODE_BYPASS) |=> (cfg_o.bypass && !cfg_o.pll_on && core_clk_en_o
                                      && cfg_o.ratio_x2 == CCR_RATIO_1X)[*2];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not 1:1 on bus clock");

  property p_clock_off;
    @(posedge clk_i) disable iff (rst_i)
      (cfg_valid_o && cfg_o.clk_off)[*2] |-> !core_clk_en_o && !clock_output_pin_o;
  endproperty
  a_clock_off: assert property (p_clock_off) else $error("core clock runs while off");

  property p_in_high;
    @(posedge clk_i) disable iff (rst_i)
      s_in_tie(1'b1, 1'b1) |-> ##2 !hysteresis_en_o && clock_output_pin_oe_o;
  endproperty
  a_in_high: assert property (p_in_high) else $error("strap high mode wrong");

  property p_in_low;
    @(posedge clk_i) disable iff (rst_i)
      s_in_tie(1'b0, 1'b0) |-> ##2 hysteresis_en_o && !clock_output_pin_oe_o;
  endproperty
  a_in_low: assert property (p_in_low) else $error("strap low mode wrong");

  property p_in_rst;
    @(posedge clk_i) disable iff (rst_i)
      s_in_tie(1'b0, 1'b1) |-> ##2 hysteresis_en_o && clock_output_pin_oe_o;
  endproperty
  a_in_rst: assert property (p_in_rst) else $error("strap on reset mode wrong");

  property p_in_inv;
    @(posedge clk_i) disable iff (rst_i)
      s_in_tie(1'b1, 1'b0) |-> ##2 !hysteresis_en_o && !clock_output_pin_oe_o;
  endproperty
  a_in_inv: assert property (p_in_inv) else $error("strap on inverse mode wrong");

  property p_out_fast;
    @(posedge clk_i) disable iff (rst_i)
      (s_out_tie(1'b0, 1'b0) or s_out_tie(1'b0, 1'b1)) |-> ##2 fast_output_timing_o;
  endproperty
  a_out_fast: assert property (p_out_fast) else $error("fast timing not chosen");

  property p_out_compat;
    @(posedge clk_i) disable iff (rst_i)
      (s_out_tie(1'b1, 1'b1) or s_out_tie(1'b1, 1'b0)) |-> ##2 !fast_output_timing_o;
  endproperty
  a_out_compat: assert property (p_out_compat) else $error("compat timing not chosen");

  property p_wb_ack;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack not a single cycle");

endmodule

// file: tb/ccr_board_model.sv
/*
  Board strapping model: drives the ratio, input mode and output mode straps.
  Assumes the bench picks a wiring class per strap and drives hard reset.
*/
`timescale 1ns/1ns
module ccr_board_model (
  input  wire logic       hard_reset_n_i,
  input  wire logic [3:0] code_i,
  input  ccr_pkg::ccr_strap_t in_cls_i,
  input  ccr_pkg::ccr_strap_t out_cls_i,
  output logic [3:0]      ratio_strap_o,
  output logic            input_mode_strap_o,
  output logic            output_mode_strap_o
);
  import ccr_pkg::*;

  function automatic logic level(input ccr_strap_t c, input logic hr_n);
    case (c)
      CCR_TIE_HIGH: level = 1'b1;
      CCR_TIE_LOW:  level = 1'b0;
      CCR_TIE_RST:  level = hr_n;
      default:      level = ~hr_n;
    endcase
  endfunction

  // bypass and odd codes are used here for test only, as a factory board would
  assign ratio_strap_o       = code_i;
  assign input_mode_strap_o  = level(in_cls_i, hard_reset_n_i);
  assign output_mode_strap_o = level(out_cls_i, hard_reset_n_i);
endmodule

// file: tb/ccr_top_bench.sv
/*
  Self-checking bench for the strap decoder: all ratio codes, all wirings,
  the Wishbone status and control registers.
  Assumes the board model drives the straps from the bench's choices.
*/
`timescale 1ns/1ns
module ccr_top_bench;
  import ccr_pkg::*;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hr_n = 1'b0;
  logic [3:0] code = 4'h0;
  ccr_strap_t in_cls = CCR_TIE_HIGH;
  ccr_strap_t out_cls = CCR_TIE_HIGH;
  logic [3:0] ratio_s;
  logic in_s, out_s;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0, wb_rdat;
  logic wb_ack, cfg_valid, core_en, hyst, fast, pin, pin_oe;
  ccr_cfg_t cfg;
  int bad_count = 0;
  int comparisons = 0;

  // expected core:bus ratio times two, one nibble per code
  localparam logic [63:0] RATIO_TAB = 64'h07c3a8b695d42e22;

  always #50 clk_i = ~clk_i;

  ccr_board_model board (.hard_reset_n_i(hr_n), .code_i(code), .in_cls_i(in_cls),
    .out_cls_i(out_cls), .ratio_strap_o(ratio_s), .input_mode_strap_o(in_s),
    .output_mode_strap_o(out_s));

  ccr_top uut (.clk_i(clk_i), .rst_i(rst_i), .hard_reset_n_i(hr_n),
    .ratio_strap_i(ratio_s), .input_mode_strap_i(in_s), .output_mode_strap_i(out_s),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .cfg_o(cfg), .cfg_valid_o(cfg_valid), .core_clk_en_o(core_en),
    .hysteresis_en_o(hyst), .fast_output_timing_o(fast),
    .clock_output_pin_o(pin), .clock_output_pin_oe_o(pin_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb_access(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                           output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_wdat <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack === 1'b1) break;
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n == 20) begin
      bad_count++;
      $display("BAD wb_ack expected 1 seen 0");
      give_verdict();
    end
    @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one hard reset cycle with a given code and wiring, then judge cfg, cfg_valid, core enable, modes and status
  task automatic strap_case(input logic [3:0] c, input ccr_strap_t ic, input ccr_strap_t oc);
    ccr_cfg_t e;
    logic h, oe, f;
    logic [31:0] rd;
    @(posedge clk_i);
    hr_n <= 1'b0;
    code <= c;
    in_cls <= ic;
    out_cls <= oc;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check("cfg_valid low", 32'h0, {31'h0, cfg_valid});
    @(posedge clk_i);
    hr_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    e.ratio_x2 = RATIO_TAB[c*4 +: 4];
    e.vco_mult = (c == 4'h1) ? 4'h8 : 4'h2;
    e.bypass = (c == 4'h3);
    e.clk_off = (c == 4'hf);
    e.pll_on = !(c == 4'h3 || c == 4'hf);
    h = (ic == CCR_TIE_LOW || ic == CCR_TIE_RST);
    oe = (ic == CCR_TIE_HIGH || ic == CCR_TIE_RST);
    f = (oc == CCR_TIE_LOW || oc == CCR_TIE_RST);
    check("cfg", {21'h0, e}, {21'h0, cfg});
    check("cfg_valid", 32'h1, {31'h0, cfg_valid});
    check("core_clk_en", {31'h0, !e.clk_off}, {31'h0, core_en});
    check("modes", {29'h0, h, oe, f}, {29'h0, hyst, pin_oe, fast});
    wb_access(1'b0, 4'h0, 32'h0, rd);
    check("status", {7'h0, oc, ic, 2'b11, f, oe, h, 1'b1, e, c}, rd);
  endtask

  // clock output toggles when running, mask forces low, clock off holds low
  task automatic clock_output_pin_case();
    logic [31:0] rd;
    logic p0;
    strap_case(4'h4, CCR_TIE_HIGH, CCR_TIE_HIGH);
    @(negedge clk_i);
    p0 = pin;
    @(negedge clk_i);
    check("clock_output_pin toggles", {31'h0, ~p0}, {31'h0, pin});
    wb_access(1'b1, 4'h4, 32'h1, rd);
    wb_access(1'b0, 4'h4, 32'h0, rd);
    check("ctrl readback", 32'h1, rd);
    repeat (2) begin
      @(negedge clk_i);
      check("clock_output_pin masked", 32'h0, {31'h0, pin});
    end
    wb_access(1'b1, 4'h4, 32'h0, rd);
    wb_access(1'b0, 4'h8, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    strap_case(4'hf, CCR_TIE_HIGH, CCR_TIE_LOW);
    repeat (2) begin
      @(negedge clk_i);
      check("clock_output_pin stopped", 32'h0, {31'h0, pin});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check("oe after reset", 32'h1, {31'h0, pin_oe});
    for (i = 0; i < 16; i++) begin
      strap_case(i[3:0], ccr_strap_t'(i[1:0]), ccr_strap_t'(i[3:2]));
    end
    clock_output_pin_case();
    give_verdict();
  end
endmodule
